// ==== core/rcp_pkg.sv ====
// Purpose: shared constants and types of the remote command parser
// Assumes: one clock, AHB-Lite register access, 32-bit data
// Notes: offsets are byte addresses, one word per register
package rcp_pkg;
    // Register offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_TALK = 8'h04;
    localparam logic [7:0] A_SPOLL = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0c;
    localparam logic [7:0] A_MEAS = 8'h10;
    localparam logic [7:0] A_DISP0 = 8'h14;
    localparam logic [7:0] A_DISP1 = 8'h18;
    localparam logic [7:0] A_SET = 8'h1c;
    localparam logic [7:0] A_IRQ_ST = 8'h20;
    localparam logic [7:0] A_IRQ_MSK = 8'h24;
    // Command and talker word fields
    localparam int CMD_EOM_BIT = 8;
    localparam int TALK_VALID_BIT = 8;
    // Status byte bit positions
    localparam int ST_DRDY = 0;
    localparam int ST_ERR = 2;
    localparam int ST_LOCAL = 4;
    localparam int ST_PON = 5;
    localparam int ST_SRQ = 6;
    localparam int MASK_W = 5;
    // Interrupt status bit positions
    localparam int IRQ_W = 3;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_REC = 1;
    localparam int IRQ_SRQ = 2;
    // Reset values
    localparam logic [MASK_W-1:0] MASK_RST = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 3'h0;
    // Characters
    localparam logic [6:0] CH_SP = 7'h20;
    localparam logic [6:0] CH_COMMA = 7'h2c;
    localparam logic [6:0] CH_SEMI = 7'h3b;
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_NINE = 7'h39;
    localparam logic [6:0] CH_LC_A = 7'h61;
    localparam logic [6:0] CH_LC_Z = 7'h7a;
    localparam logic [6:0] CH_UC_A = 7'h41;
    localparam logic [6:0] CH_UC_Z = 7'h5a;
    localparam logic [6:0] CH_CASE = 7'h20;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_BLANK = 8'h20;
    localparam logic [7:0] REC_PREFIX = 8'h46;
    // Talker buffer and record shape
    localparam int TB_DEPTH = 16;
    localparam int NBLANK = 2;
    localparam int NDIG = 5;
    localparam int ID_LEN = 8;
    // Identity text, arbitrary value
    localparam logic [ID_LEN-1:0][7:0] ID_TEXT = {
        8'h46, 8'h52, 8'h51, 8'h2d, 8'h30, 8'h30, 8'h30, 8'h31};
    // Two-letter mnemonics, upper case
    localparam logic [13:0] MN_MEASUREMENT_FUNCTION_SELECT = {7'h46, 7'h55};
    localparam logic [13:0] MN_INPUT_ATTENUATOR_SELECT = {7'h41, 7'h54};
    localparam logic [13:0] MN_LOWPASS_FILTER_SELECT = {7'h46, 7'h49};
    localparam logic [13:0] MN_INPUT_OPTION_SELECT = {7'h4d, 7'h4c};
    localparam logic [13:0] MN_GATE_TIME_SELECT = {7'h47, 7'h41};
    localparam logic [13:0] MN_COMMAND_FINALIZER = {7'h44, 7'h4e};
    localparam logic [13:0] MN_SRQ_MASK_LOAD = {7'h53, 7'h4d};
    localparam logic [13:0] MN_IDENTITY_QUERY = {7'h49, 7'h44};
    localparam logic [13:0] MN_REMOTE_DISPLAY_WRITE = {7'h44, 7'h52};
    localparam logic [13:0] MN_FREQ_A_QUERY = {7'h49, 7'h4e};
    localparam logic [7:0] FUNC_ILLEGAL = 8'h05;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_LET1 = 2'b01,
        PS_ARGS = 2'b11,
        PS_TEXT = 2'b10
    } rcp_pstate_t;

    typedef struct packed {
        logic [6:0] up;
        logic letter;
        logic digit;
        logic term;
        logic [3:0] val;
    } rcp_char_t;

    typedef struct packed {
        logic exp_neg;
        logic [3:0] exp_dig;
        logic neg;
        logic [2:0] dp;
        logic [NDIG*4-1:0] digits;
    } rcp_meas_t;

    typedef struct packed {
        logic [TB_DEPTH-1:0][7:0] buf_;
        logic [4:0] len;
    } rcp_tbuf_t;
endpackage

// ==== core/rcp_char_class.sv ====
// Purpose: classify one received command character
// Assumes: eighth bit is parity
// Notes: purely combinational
`timescale 1ns/10ps
module rcp_char_class
    import rcp_pkg::*;
(
    input wire logic [7:0] raw,
    output rcp_char_t cls
);
    logic [6:0] c;

    assign c = raw[6:0];

    always_comb begin
        cls = '0;
        cls.up = (c >= CH_LC_A && c <= CH_LC_Z) ? c - CH_CASE : c;
        cls.letter = (cls.up >= CH_UC_A) && (cls.up <= CH_UC_Z);
        cls.digit = (c >= CH_ZERO) && (c <= CH_NINE);
        cls.term = (c == CH_SP) || (c == CH_COMMA) || (c == CH_SEMI);
        cls.val = c[3:0];
    end
endmodule

// ==== core/rcp_parser.sv ====
// Purpose: remote command parser with AHB-Lite register access
// Assumes: single clock hclk, async active-low reset, ce freezes all state
// Notes: zero-wait-state slave, read data registered in the address phase
`timescale 1ns/10ps
module rcp_parser
    import rcp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic srq
);
    typedef struct packed {
        rcp_pstate_t pstate;
        logic [13:0] mn;
        logic [7:0] arg;
        logic [3:0] func;
        logic [3:0] att;
        logic [3:0] filt;
        logic [3:0] opt;
        logic [3:0] gate;
        logic [MASK_W-1:0] mask;
        logic drdy;
        logic err;
        logic pon;
        logic srq;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic irq;
        rcp_meas_t meas;
        rcp_tbuf_t tb;
        logic [4:0] tb_ptr;
        logic [7:0][7:0] disp;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } rcp_state_t;

    rcp_state_t s_q;
    rcp_state_t s_d;
    rcp_char_t ch;
    logic acc;
    logic hit;
    logic exec;
    logic eom;
    logic err_ev;
    logic rec_ev;
    logic srq_ev;
    logic [13:0] em;
    logic [7:0] ea;
    logic [7:0] st_old;
    logic [7:0] st_new;

    function automatic logic [7:0] stat_byte(input rcp_state_t st);
        logic [7:0] b;
        b = '0;
        b[ST_DRDY] = st.drdy;
        b[ST_ERR] = st.err;
        b[ST_PON] = st.pon;
        b[ST_SRQ] = st.srq;
        return b;
    endfunction

    function automatic rcp_tbuf_t build_record(input rcp_meas_t m);
        rcp_tbuf_t t;
        int k;
        t = '0;
        t.buf_[0] = REC_PREFIX;
        k = 1;
        for (int b = 0; b < NBLANK; b++) begin
            t.buf_[k[3:0]] = CH_BLANK;
            k++;
        end
        t.buf_[k[3:0]] = m.neg ? CH_MINUS : CH_PLUS;
        k++;
        if (m.dp == 3'h0) begin
            t.buf_[k[3:0]] = CH_DOT;
            k++;
        end
        for (int i = 0; i < NDIG; i++) begin
            t.buf_[k[3:0]] = {1'b0, CH_ZERO} | {4'h0, m.digits[4*(NDIG-1-i) +: 4]};
            k++;
            if (m.dp == 3'(i + 1) || (i == NDIG - 1 && m.dp > 3'(NDIG))) begin
                t.buf_[k[3:0]] = CH_DOT;
                k++;
            end
        end
        t.buf_[k[3:0]] = CH_E;
        t.buf_[4'(k + 1)] = m.exp_neg ? CH_MINUS : CH_PLUS;
        t.buf_[4'(k + 2)] = {4'h3, m.exp_dig};
        t.buf_[4'(k + 3)] = CH_CR;
        t.buf_[4'(k + 4)] = CH_LF;
        t.len = 5'(k + 5);
        return t;
    endfunction

    function automatic rcp_tbuf_t build_id();
        rcp_tbuf_t t;
        t = '0;
        for (int i = 0; i < ID_LEN; i++) begin
            t.buf_[i] = ID_TEXT[ID_LEN-1-i];
        end
        t.buf_[ID_LEN] = CH_CR;
        t.buf_[ID_LEN+1] = CH_LF;
        t.len = 5'(ID_LEN + 2);
        return t;
    endfunction

    rcp_char_class u_class (
        .raw(hwdata[7:0]),
        .cls(ch)
    );

    assign acc = hsel && htrans[1] && hready;
    assign hit = (haddr[31:8] == 24'h000000);

    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.resp = 1'b0;
        exec = 1'b0;
        err_ev = 1'b0;
        rec_ev = 1'b0;
        srq_ev = 1'b0;
        eom = hwdata[CMD_EOM_BIT];
        em = s_q.mn;
        ea = s_q.arg;
        st_old = stat_byte(s_q);

        // Address phase: reads answer now, writes wait for hwdata
        // Write data phase lasts one cycle only
        s_d.wr_pend = acc && hwrite;
        if (acc) begin
            s_d.wr_addr = hit ? haddr[7:0] : 8'hff;
        end
        if (acc && !hwrite) begin
            s_d.rdata = 32'h00000000;
            if (!hit) begin
                s_d.rdata = 32'h00000000;
            end else if (haddr[7:0] == A_CMD) begin
                s_d.rdata = {30'h00000000, s_q.pstate};
            end else if (haddr[7:0] == A_TALK) begin
                if (s_q.tb_ptr < s_q.tb.len) begin
                    s_d.rdata = {23'h000000, 1'b1, s_q.tb.buf_[s_q.tb_ptr[3:0]]};
                    s_d.tb_ptr = s_q.tb_ptr + 5'h01;
                end
            end else if (haddr[7:0] == A_SPOLL) begin
                s_d.rdata = {24'h000000, stat_byte(s_q)};
                s_d.srq = 1'b0;
                s_d.err = 1'b0;
                s_d.pon = 1'b0;
            end else if (haddr[7:0] == A_MASK) begin
                s_d.rdata = {27'h0000000, s_q.mask};
            end else if (haddr[7:0] == A_MEAS) begin
                s_d.rdata = {3'h0, s_q.meas};
            end else if (haddr[7:0] == A_DISP0) begin
                s_d.rdata = s_q.disp[3:0];
            end else if (haddr[7:0] == A_DISP1) begin
                s_d.rdata = s_q.disp[7:4];
            end else if (haddr[7:0] == A_SET) begin
                s_d.rdata = {12'h000, s_q.func, s_q.att, s_q.filt, s_q.opt, s_q.gate};
            end else if (haddr[7:0] == A_IRQ_ST) begin
                s_d.rdata = {29'h00000000, s_q.irq_st};
                s_d.irq_st = '0;
            end else if (haddr[7:0] == A_IRQ_MSK) begin
                s_d.rdata = {29'h00000000, s_q.irq_msk};
            end
        end

        // Data phase of a write
        if (s_q.wr_pend) begin
            if (s_q.wr_addr == A_MASK) begin
                s_d.mask = hwdata[MASK_W-1:0];
            end else if (s_q.wr_addr == A_MEAS) begin
                s_d.meas = hwdata[28:0];
                s_d.drdy = 1'b1;
            end else if (s_q.wr_addr == A_IRQ_MSK) begin
                s_d.irq_msk = hwdata[IRQ_W-1:0];
            end else if (s_q.wr_addr == A_CMD) begin
                // One character of the command stream
                case (s_q.pstate)
                    PS_TEXT: begin
                        s_d.disp = {s_q.disp[6:0], {1'b0, hwdata[6:0]}};
                        if (eom) begin
                            s_d.pstate = PS_IDLE;
                        end
                    end
                    PS_IDLE: begin
                        if (ch.letter) begin
                            s_d.mn = {ch.up, 7'h00};
                            s_d.pstate = eom ? PS_IDLE : PS_LET1;
                            err_ev = eom;
                        end else if (!ch.term) begin
                            err_ev = 1'b1;
                        end
                    end
                    PS_LET1: begin
                        if (ch.letter) begin
                            s_d.mn = {s_q.mn[13:7], ch.up};
                            s_d.arg = 8'h00;
                            s_d.pstate = PS_ARGS;
                            em = {s_q.mn[13:7], ch.up};
                            ea = 8'h00;
                            exec = eom;
                            if (eom) begin
                                s_d.pstate = PS_IDLE;
                            end
                        end else begin
                            err_ev = 1'b1;
                            s_d.pstate = PS_IDLE;
                        end
                    end
                    PS_ARGS: begin
                        if (ch.digit) begin
                            ea = 8'(s_q.arg * 8'd10 + {4'h0, ch.val});
                            s_d.arg = ea;
                            exec = eom;
                            if (eom) begin
                                s_d.pstate = PS_IDLE;
                            end
                        end else if (ch.term) begin
                            exec = 1'b1;
                            s_d.pstate = PS_IDLE;
                        end else if (ch.letter) begin
                            exec = 1'b1;
                            s_d.mn = {ch.up, 7'h00};
                            s_d.pstate = eom ? PS_IDLE : PS_LET1;
                            err_ev = eom;
                        end else begin
                            err_ev = 1'b1;
                            s_d.pstate = PS_IDLE;
                        end
                    end
                    default: begin
                        s_d.pstate = PS_IDLE;
                    end
                endcase
            end
        end

        // Act on a completed command
        if (exec) begin
            case (em)
                MN_MEASUREMENT_FUNCTION_SELECT: begin
                    if (ea == FUNC_ILLEGAL) begin
                        err_ev = 1'b1;
                    end else begin
                        s_d.func = ea[3:0];
                    end
                end
                MN_INPUT_ATTENUATOR_SELECT: begin
                    s_d.att = ea[3:0];
                end
                MN_LOWPASS_FILTER_SELECT: begin
                    s_d.filt = ea[3:0];
                end
                MN_INPUT_OPTION_SELECT: begin
                    s_d.opt = ea[3:0];
                end
                MN_GATE_TIME_SELECT: begin
                    s_d.gate = ea[3:0];
                end
                MN_COMMAND_FINALIZER: begin
                    s_d.mn = s_d.mn;
                end
                MN_SRQ_MASK_LOAD: begin
                    s_d.mask = ea[MASK_W-1:0];
                end
                MN_IDENTITY_QUERY: begin
                    s_d.tb = build_id();
                    s_d.tb_ptr = 5'h00;
                    rec_ev = 1'b1;
                end
                MN_FREQ_A_QUERY: begin
                    s_d.tb = build_record(s_q.meas);
                    s_d.tb_ptr = 5'h00;
                    s_d.drdy = 1'b0;
                    rec_ev = 1'b1;
                end
                MN_REMOTE_DISPLAY_WRITE: begin
                    s_d.disp = '0;
                    if (!eom) begin
                        s_d.pstate = PS_TEXT;
                    end
                end
                default: begin
                    err_ev = 1'b1;
                end
            endcase
        end

        if (err_ev) begin
            s_d.err = 1'b1;
        end

        // Service request on a newly set, unmasked status bit
        st_new = stat_byte(s_d);
        if (|(st_new[MASK_W-1:0] & ~st_old[MASK_W-1:0] & s_d.mask)) begin
            s_d.srq = 1'b1;
            srq_ev = !s_q.srq;
        end

        s_d.irq_st[IRQ_ERR] = s_d.irq_st[IRQ_ERR] | err_ev;
        s_d.irq_st[IRQ_REC] = s_d.irq_st[IRQ_REC] | rec_ev;
        s_d.irq_st[IRQ_SRQ] = s_d.irq_st[IRQ_SRQ] | srq_ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_msk);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.mask <= MASK_RST;
            s_q.irq_msk <= IRQ_MSK_RST;
            s_q.pon <= 1'b1;
            s_q.ready <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.ready;
    assign hresp = s_q.resp;
    assign irq = s_q.irq;
    assign srq = s_q.srq;
endmodule

// ==== test/rcp_parser_sva.sv ====
// Purpose: bus answer, service request and interrupt timing of the parser
// Assumes: zero-wait-state slave, one clock
// Notes: bound to rcp_parser from the bench top file
`timescale 1ns/10ps
module rcp_parser_sva
    import rcp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq,
    input wire logic srq
);
    logic wdp_q;
    wire logic go = hsel && htrans[1] && hready && ce;
    wire logic rd_go = go && !hwrite;
    wire logic mapped = haddr[31:8] == 24'h0;
    wire logic poll = rd_go && mapped && haddr[7:0] == A_SPOLL;
    wire logic irqrd = rd_go && mapped && haddr[7:0] == A_IRQ_ST;
    // Marks a write data phase, the only moment srq and irq can rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdp_q <= 1'b0;
        end else begin
            wdp_q <= go && hwrite;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    srq_rise_a: assert property ($rose(srq) |-> $past(wdp_q))
        else $error("service request rose without a write");
    srq_fall_a: assert property ($fell(srq) |-> $past(poll))
        else $error("service request fell without a poll");
    srq_clear_a: assert property (poll && !wdp_q && !$past(wdp_q) |-> ##[1:3] !srq)
        else $error("poll did not clear service request");
    irq_rise_a: assert property ($rose(irq) |-> $past(wdp_q))
        else $error("interrupt rose without a write");
    irq_clear_a: assert property (irqrd && !wdp_q && !$past(wdp_q) |-> ##[1:3] !irq)
        else $error("status read did not clear interrupt");
    rdata_hold_a: assert property (!rd_go |=> $stable(hrdata))
        else $error("read data changed without a read");
    unmapped_a: assert property (rd_go && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
endmodule

// ==== test/rcp_ctl_model.sv ====
// Purpose: controller side: AHB-Lite master issuing commands and polls
// Assumes: single whole-word transfers, OKAY responses
// Notes: released write data lines carry the inverse of the last value
`timescale 1ns/10ps
module rcp_ctl_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Status byte may be fetched at any time by a poll read
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

// ==== test/remote_command_parser_tb.sv ====
// Purpose: self-checking bench of the remote command parser
// Assumes: 200 MHz clock, controller model drives the bus
// Notes: command strings go one character per write, last one with end of message
`timescale 1ns/10ps
module remote_command_parser_tb
    import rcp_pkg::*;
;
    logic hclk;
    logic hresetn;
    wire logic ce = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, irq, srq;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] m [3] = '{32'h00312345, 32'h11b12345, 32'h00712345};
    string r [3] = '{"F  +123.45E+0\015\012", "F  -123.45E-1\015\012",
                     "F  +12345.E+0\015\012"};

    rcp_parser dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .srq(srq));
    rcp_ctl_model ctl_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ctl_u.xfer(32'(a), 1'b1, d, q);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        ctl_u.xfer(a, 1'b0, 32'h0, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(32'(a), q);
        chk(q, exp);
    endtask
    task automatic send(input string s, input logic [7:0] par);
        for (int i = 0; i < s.len(); i++) begin
            wr(A_CMD, {23'h0, 1'(i == s.len() - 1), s[i] | par});
        end
    endtask
    // Pops the talker queue and expects it empty afterwards
    task automatic talk(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rdchk(A_TALK, {23'h0, 1'b1, s[i]});
        end
        rdchk(A_TALK, 32'h0);
    endtask
    task automatic settle();
        repeat (4) @(posedge hclk);
        #1;
    endtask

    initial begin
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(A_SPOLL, 32'h20);
        rdchk(A_SPOLL, 32'h0);
        rdchk(A_MASK, 32'h0);
        rdchk(A_IRQ_MSK, 32'h0);
        send("\163m255", 8'h00);
        rdchk(A_MASK, 32'h1f);
        send("\123M5", 8'h80);
        rdchk(A_MASK, 32'h05);
        wr(A_IRQ_MSK, 32'h7);
        rd(32'(A_IRQ_ST), v);
        send("\106U5", 8'h00);
        settle();
        chk(32'(srq), 32'h1);
        chk(32'(irq), 32'h1);
        rdchk(A_SPOLL, 32'h44);
        rdchk(A_IRQ_ST, 32'h5);
        settle();
        chk(32'(irq), 32'h0);
        chk(32'(srq), 32'h0);
        wr(A_IRQ_MSK, 32'h0);
        send("\106U5", 8'h00);
        settle();
        chk(32'(irq), 32'h0);
        rdchk(A_IRQ_ST, 32'h5);
        rdchk(A_SPOLL, 32'h44);
        rdchk(A_SET, 32'h0);
        send("\146u1,\141t2;\146i3 \155l4,\147a2", 8'h00);
        rdchk(A_SET, 32'h12342);
        send("\106U3 \101T0;\106I0,\115L0 \107A1", 8'h80);
        rdchk(A_SET, 32'h30001);
        send("\123M1", 8'h00);
        wr(A_MEAS, m[0]);
        settle();
        chk(32'(srq), 32'h1);
        rdchk(A_SPOLL, 32'h41);
        for (int i = 0; i < 3; i++) begin
            wr(A_MEAS, m[i]);
            send("IN", 8'h00);
            talk(r[i]);
        end
        rdchk(A_SPOLL, 32'h40);
        send("\151d", 8'h00);
        talk("FRQ-0001\015\012");
        send("\104R WXYZ", 8'h00);
        rdchk(A_DISP0, 32'h5758595a);
        wr(8'h00, 32'h0);
        rdchk(A_SPOLL, 32'h04);
        ctl_u.xfer(32'h10c, 1'b1, 32'hffffffff, v);
        rdchk(A_MASK, 32'h01);
        rd(32'h100, v);
        chk(v, 32'h0);
        report_and_stop();
    end
endmodule

bind rcp_parser rcp_parser_sva chk_u (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .srq(srq));
